// [rtl/adcbs_sequencer.sv]
// Purpose: burst-mode conversion sequencer with apb registers
// Assumes: ref_clk is the 25 MHz burst clock; converter core answers conv_done
// Notes: starts are pulses; status bits clear on read, a set in the same cycle wins
`timescale 1ns/100ps
`include "adcbs_consts.svh"
module adcbs_sequencer #(
   parameter int DATA_W = 10,
   parameter int SUM_W = 16
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // conversion start trigger
   input wire logic ext_start,
   // converter core
   output logic conv_power,
   output logic conv_track,
   output logic conv_start,
   input wire logic conv_done,
   input wire logic [DATA_W-1:0] conv_data,
   // interrupt
   output logic irq
);

   // configuration registers
   logic converter_enable;
   logic burst_enable;
   logic extra_tracking;
   logic [2:0] repeat_sel;
   logic [3:0] power_up_time;
   logic [3:0] tracking_time;
   logic [SUM_W-1:0] gt_limit;
   logic [SUM_W-1:0] lt_limit;
   logic [2:0] status;
   logic [2:0] mask;

   // sequencer state
   adcbs_pkg::adcbs_state_t state;
   adcbs_pkg::adcbs_state_t next_state;
   logic [6:0] repeat_cnt;
   logic [6:0] conv_cnt;
   logic [SUM_W-1:0] accum;
   logic [SUM_W-1:0] result;
   logic in_burst;
   logic power_on;

   // apb decode
   logic wr_en;
   logic rd_en;
   logic hit_ctrl;
   logic hit_pwr;
   logic hit_track;
   logic hit_status;
   logic hit_mask;
   logic hit_result;
   logic hit_gt;
   logic hit_lt;
   logic hit_state;
   logic mapped;

   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & penable & ~pwrite;
   assign hit_ctrl = (paddr == `ADCBS_CTRL_OFS);
   assign hit_pwr = (paddr == `ADCBS_PWR_OFS);
   assign hit_track = (paddr == `ADCBS_TRACK_OFS);
   assign hit_status = (paddr == `ADCBS_STATUS_OFS);
   assign hit_mask = (paddr == `ADCBS_MASK_OFS);
   assign hit_result = (paddr == `ADCBS_RESULT_OFS);
   assign hit_gt = (paddr == `ADCBS_GT_OFS);
   assign hit_lt = (paddr == `ADCBS_LT_OFS);
   assign hit_state = (paddr == `ADCBS_STATE_OFS);
   assign mapped = hit_ctrl | hit_pwr | hit_track | hit_status | hit_mask |
                   hit_result | hit_gt | hit_lt | hit_state;

   // zero wait states, error on unmapped address
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   // read data mux
   logic [31:0] rd_mux;
   assign rd_mux =
      hit_ctrl   ? {23'h000000, 1'b0, 1'b0, repeat_sel, 1'b0, extra_tracking,
                    burst_enable, converter_enable} :
      hit_pwr    ? {28'h0000000, power_up_time} :
      hit_track  ? {28'h0000000, tracking_time} :
      hit_status ? {29'h00000000, status} :
      hit_mask   ? {29'h00000000, mask} :
      hit_result ? {{(32-SUM_W){1'b0}}, result} :
      hit_gt     ? {{(32-SUM_W){1'b0}}, gt_limit} :
      hit_lt     ? {{(32-SUM_W){1'b0}}, lt_limit} :
      hit_state  ? {25'h0000000, conv_cnt} :
      32'h00000000;
   assign prdata = rd_en ? rd_mux : 32'h00000000;

   // start request: software write or external pulse
   logic sw_start;
   logic start_req;
   assign sw_start = wr_en & hit_ctrl & pwdata[`ADCBS_CTRL_START_BIT];
   assign start_req = sw_start | ext_start;

   // repeat code to conversion count, unused codes give one
   function automatic logic [6:0] rep_decode(input logic [2:0] code);
      logic [6:0] n;
      n = 7'h01;
      case (code)
         3'h1: n = 7'h04;
         3'h2: n = 7'h08;
         3'h3: n = 7'h10;
         3'h4: n = 7'h20;
         3'h5: n = 7'h40;
         default: n = 7'h01;
      endcase
      return n;
   endfunction

   // timer loads
   logic pwr_load;
   logic trk_load;
   logic pwr_busy;
   logic trk_busy;
   logic [7:0] pwr_cycles;
   logic [7:0] trk_cycles;
   logic [7:0] step_cyc;
   logic [7:0] xtrk_cyc;

   assign step_cyc = 8'(`ADCBS_PWR_STEP_CYC);
   assign xtrk_cyc = 8'(`ADCBS_XTRK_CYC);
   // power-up delay in ref_clk cycles, one less since the timer's zero cycle counts too
   assign pwr_cycles = 8'(({4'h0, power_up_time} + 8'h01) * step_cyc - 8'h01);
   // tracking time plus one, plus optional three extra clocks
   assign trk_cycles = {4'h0, tracking_time} + 8'h01 +
                       (extra_tracking ? xtrk_cyc : 8'h00);

   adcbs_down_counter #(
      .W(8)
   ) u_pwr_timer (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .load(pwr_load),
      .load_value(pwr_cycles),
      .busy(pwr_busy)
   );

   adcbs_down_counter #(
      .W(8)
   ) u_trk_timer (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .load(trk_load),
      .load_value(trk_cycles),
      .busy(trk_busy)
   );

   // conversion bookkeeping
   logic conv_ok;
   logic last_conv;
   logic idle;
   logic accept;
   logic [SUM_W-1:0] sum_next;
   assign idle = (state == adcbs_pkg::ST_IDLE);
   assign conv_ok = (state == adcbs_pkg::ST_CONVERT) & conv_done;
   assign last_conv = (conv_cnt + 7'h01 == repeat_cnt);
   assign sum_next = accum + SUM_W'(conv_data);
   // a start is taken only when idle and a converter can run
   assign accept = start_req & idle & (burst_enable | converter_enable);

   // next state
   always_comb begin
      next_state = state;
      pwr_load = 1'b0;
      trk_load = 1'b0;
      unique case (state)
         adcbs_pkg::ST_IDLE: begin
            if (accept) begin
               if (burst_enable & ~power_on) begin
                  next_state = adcbs_pkg::ST_POWERUP;
                  pwr_load = 1'b1;
               end else begin
                  next_state = adcbs_pkg::ST_TRACK;
                  trk_load = 1'b1;
               end
            end
         end
         adcbs_pkg::ST_POWERUP: begin
            if (!pwr_busy) begin
               next_state = adcbs_pkg::ST_TRACK;
               trk_load = 1'b1;
            end
         end
         adcbs_pkg::ST_TRACK: begin
            if (!trk_busy) begin
               next_state = adcbs_pkg::ST_CONVERT;
            end
         end
         adcbs_pkg::ST_CONVERT: begin
            if (conv_done) begin
               if (last_conv) begin
                  next_state = adcbs_pkg::ST_DONE;
               end else if (in_burst) begin
                  next_state = adcbs_pkg::ST_TRACK;
                  trk_load = 1'b1;
               end else begin
                  next_state = adcbs_pkg::ST_IDLE;
               end
            end
         end
         adcbs_pkg::ST_DONE: begin
            next_state = adcbs_pkg::ST_IDLE;
         end
         default: begin
            next_state = adcbs_pkg::ST_IDLE;
         end
      endcase
   end

   // state register, runs on the burst clock alone
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state <= adcbs_pkg::ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // repeat count and mode latched at the start of a sequence
   logic seq_open;
   assign seq_open = accept & (conv_cnt == 7'h00);
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         repeat_cnt <= 7'h01;
         in_burst <= 1'b0;
      end else if (seq_open) begin
         repeat_cnt <= rep_decode(repeat_sel);
         in_burst <= burst_enable;
      end
   end

   // conversion counter and accumulator
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         conv_cnt <= 7'h00;
         accum <= '0;
         result <= '0;
      end else if (conv_ok) begin
         if (last_conv) begin
            conv_cnt <= 7'h00;
            accum <= '0;
            result <= sum_next;
         end else begin
            conv_cnt <= conv_cnt + 7'h01;
            accum <= sum_next;
         end
      end
   end

   // converter power: burst idle state follows converter_enable
   logic next_power;
   assign next_power = burst_enable ? (converter_enable | ~idle | accept)
                                    : converter_enable;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         power_on <= 1'b0;
      end else begin
         power_on <= next_power;
      end
   end

   // converter strobes
   logic next_conv_start;
   assign next_conv_start = (state == adcbs_pkg::ST_TRACK) & ~trk_busy;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         conv_start <= 1'b0;
         conv_track <= 1'b0;
      end else begin
         conv_start <= next_conv_start;
         conv_track <= (next_state == adcbs_pkg::ST_TRACK);
      end
   end
   assign conv_power = power_on;

   // events for the status register
   logic ev_done;
   logic ev_win;
   logic ev_ovr;
   logic [2:0] ev_set;
   assign ev_done = (state == adcbs_pkg::ST_DONE);
   // window compare only on the finished sum
   assign ev_win = ev_done & ((result > gt_limit) | (result < lt_limit));
   // a start that cannot be taken is reported
   assign ev_ovr = start_req & ~accept;
   assign ev_set = {ev_ovr, ev_win, ev_done};

   // sticky status, read clears, set wins
   logic [2:0] next_status;
   assign next_status = (rd_en & hit_status) ? ev_set : (status | ev_set);
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         status <= 3'h0;
      end else begin
         status <= next_status;
      end
   end

   // level interrupt
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(next_status & mask);
      end
   end

   // control register writes
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         converter_enable <= 1'b0;
         burst_enable <= 1'b0;
         extra_tracking <= 1'b0;
         repeat_sel <= 3'h0;
      end else if (wr_en & hit_ctrl) begin
         converter_enable <= pwdata[`ADCBS_CTRL_EN_BIT];
         burst_enable <= pwdata[`ADCBS_CTRL_BURST_BIT];
         extra_tracking <= pwdata[`ADCBS_CTRL_XTRK_BIT];
         repeat_sel <= pwdata[`ADCBS_CTRL_REP_LSB +: 3];
      end
   end

   // timing register writes
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         power_up_time <= `ADCBS_PWR_RST;
         tracking_time <= `ADCBS_TRACK_RST;
      end else begin
         if (wr_en & hit_pwr) begin
            power_up_time <= pwdata[3:0];
         end
         if (wr_en & hit_track) begin
            tracking_time <= pwdata[3:0];
         end
      end
   end

   // window limits and mask
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         gt_limit <= `ADCBS_GT_RST;
         lt_limit <= `ADCBS_LT_RST;
         mask <= 3'h0;
      end else begin
         if (wr_en & hit_gt) begin
            gt_limit <= pwdata[SUM_W-1:0];
         end
         if (wr_en & hit_lt) begin
            lt_limit <= pwdata[SUM_W-1:0];
         end
         if (wr_en & hit_mask) begin
            mask <= pwdata[2:0];
         end
      end
   end

endmodule

// [rtl/adcbs_consts.svh]
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 32-bit apb data, byte addresses, ref_clk at 25 MHz
// Notes: definitions only
// Operation
// - burst mode runs only while burst_enable is one; the code finishes a started burst after burst_enable clears
// - repeat count per burst is 1, 4, 8, 16, 32 or 64
// - burst conversions run on an independent clock of about 25 MHz
// - a whole burst finishes and powers down without the system clock
// - burst mode with converter_enable zero powers down after each burst
// - burst mode with converter_enable one keeps the converter powered
// - a start wakes a powered-down converter, then waits power-up time; the code does so only in burst mode and refuses it otherwise
// - an already powered converter starts tracking at once
// - one start in burst mode gives repeat-count conversions
// - done flag is set only after repeat-count conversions are summed
// - window compare waits until repeat-count conversions are summed
// - burst tracking comes from tracking time and extra_tracking
// - extra_tracking adds three converter clocks of tracking per conversion
// - power-up delay is power_up_time plus one, times 400 ns
// - outside burst mode converter_enable alone sets converter power
`ifndef ADCBS_CONSTS_SVH
`define ADCBS_CONSTS_SVH

// register byte offsets
`define ADCBS_CTRL_OFS 8'h00
`define ADCBS_PWR_OFS 8'h04
`define ADCBS_TRACK_OFS 8'h08
`define ADCBS_STATUS_OFS 8'h0c
`define ADCBS_MASK_OFS 8'h10
`define ADCBS_RESULT_OFS 8'h14
`define ADCBS_GT_OFS 8'h18
`define ADCBS_LT_OFS 8'h1c
`define ADCBS_STATE_OFS 8'h20

// control fields
`define ADCBS_CTRL_EN_BIT 0
`define ADCBS_CTRL_BURST_BIT 1
`define ADCBS_CTRL_XTRK_BIT 2
`define ADCBS_CTRL_REP_LSB 4
`define ADCBS_CTRL_START_BIT 8

// status and mask bits
`define ADCBS_ST_DONE_BIT 0
`define ADCBS_ST_WIN_BIT 1
`define ADCBS_ST_OVR_BIT 2

// reset values
`define ADCBS_PWR_RST 4'hf
`define ADCBS_TRACK_RST 4'h2
`define ADCBS_GT_RST 16'hffff
`define ADCBS_LT_RST 16'h0000

// timing
`define ADCBS_CLK_PERIOD_NS 40
`define ADCBS_PWR_STEP_NS 400
`define ADCBS_PWR_STEP_CYC ((`ADCBS_PWR_STEP_NS + `ADCBS_CLK_PERIOD_NS - 1) / `ADCBS_CLK_PERIOD_NS)
`define ADCBS_XTRK_CYC 3

`endif

// [rtl/adcbs_pkg.sv]
// Purpose: types of the burst sequencer
// Assumes: nothing
// Notes: constants live in adcbs_consts.svh
package adcbs_pkg;

   // sequencer states
   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_POWERUP = 3'b001,
      ST_TRACK   = 3'b010,
      ST_CONVERT = 3'b011,
      ST_DONE    = 3'b100
   } adcbs_state_t;

endpackage

// [rtl/adcbs_down_counter.sv]
// Purpose: loadable down counter used for power-up and tracking delays
// Assumes: load_value is at least one
// Notes: busy stays high from the edge after load until the count runs out
`timescale 1ns/100ps
module adcbs_down_counter #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // control
   input wire logic load,
   input wire logic [W-1:0] load_value,
   // status
   output logic busy
);

   logic [W-1:0] count;
   logic [W-1:0] next_count;

   // load wins, otherwise count down to zero
   assign next_count = load ? load_value :
                       (count != '0) ? count - {{(W-1){1'b0}}, 1'b1} : count;
   assign busy = (count != '0);

   // counter register
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

endmodule

// [tb/adcbs_core_model.sv]
// Purpose: behavioural converter core facing the sequencer
// Assumes: lat is at least two cycles
// Notes: data lines toggle when no sample is valid
`timescale 1ns/100ps
module adcbs_core_model (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // converter link
   input wire logic conv_start,
   input wire logic [3:0] lat,
   input wire logic [9:0] sample,
   output logic conv_done,
   output logic [9:0] conv_data
);
   logic [3:0] cnt;
   // answer lat cycles after each start
   always_ff @(posedge ref_clk) begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (!rst_n) begin
         cnt <= 4'h0;
         conv_data <= 10'h000;
      end else if (conv_start) begin
         cnt <= lat;
      end else if (cnt == 4'h1) begin
         cnt <= 4'h0;
         conv_done <= 1'b1;
         conv_data <= sample;
      end else if (cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
      end
   end
endmodule

// [tb/adcbs_checker.sv]
// Purpose: port assertions of the burst sequencer
// Assumes: bound to adcbs_sequencer
// Notes: one clock domain, synchronous reset
`timescale 1ns/100ps
module adcbs_checker (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // converter link
   input wire logic conv_power,
   input wire logic conv_track,
   input wire logic conv_start
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // steps of one conversion
   sequence s_track_end;
      conv_track ##1 !conv_track;
   endsequence
   sequence s_wake;
      !conv_track ##1 conv_track;
   endsequence
   // bus answers
   a_pready_high: assert property (pready)
      else $error("pready low");
   a_slverr_access: assert property (pslverr |-> psel && penable)
      else $error("slave error outside access");
   a_prdata_idle: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0)
      else $error("read data outside read access");
   // converter sequencing
   a_track_to_start: assert property (s_track_end |-> conv_start)
      else $error("tracking ended without start");
   a_start_pulse: assert property (conv_start |=> !conv_start && !conv_track)
      else $error("start not a single pulse");
   a_track_powered: assert property (conv_track || conv_start |-> conv_power)
      else $error("converter used unpowered");
   a_track_bounded: assert property (s_wake |-> ##[0:200] conv_start)
      else $error("tracking too long");
   a_power_idle: assert property ($fell(conv_power) |->
      !$past(conv_track) && !$past(conv_start))
      else $error("power dropped in mid conversion");
endmodule
bind adcbs_sequencer adcbs_checker u_chk (.ref_clk, .rst_n, .psel, .penable, .pwrite,
   .prdata, .pready, .pslverr, .conv_power, .conv_track, .conv_start);

// [tb/testbench.sv]
// Purpose: self-checking bench of the burst sequencer
// Assumes: core model answers every conversion start
// Notes: random settings from a fixed seed
`timescale 1ns/100ps
`include "adcbs_consts.svh"
module testbench;
   logic ref_clk, rst_n, psel, penable, pwrite, ext_start, serr;
   logic pready, pslverr, conv_power, conv_track, conv_start, conv_done, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rv, ctrl;
   logic [9:0] conv_data;
   logic [9:0] sample = 10'h155;
   logic [3:0] lat = 4'h3;
   logic [15:0] sum = 16'h0;
   logic start_seen;
   logic [39:0] rst_tab [10] = '{40'h0000000000, 40'h040000000f, 40'h0800000002,
      40'h0c00000000, 40'h1000000000, 40'h1400000000, 40'h180000ffff, 40'h1c00000000,
      40'h2000000000, 40'h2400000000};
   int failures, n_tests, starts, dones, run, first_trk, mark, cyc, t0, first_lat;
   integer seed = 32'h32d3e442;
   adcbs_sequencer DUT (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .ext_start, .conv_power, .conv_track, .conv_start,
      .conv_done, .conv_data, .irq);
   adcbs_core_model u_core (.ref_clk, .rst_n, .conv_start, .lat, .sample, .conv_done,
      .conv_data);
   // clock
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // start requested of the sequencer, taken or refused: external pulse or control write with the start bit
   assign start_seen = ext_start | (psel & penable & pwrite & (paddr == `ADCBS_CTRL_OFS) &
      pwdata[`ADCBS_CTRL_START_BIT]);
   // converter link monitor, new core settings per sample
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (start_seen) t0 <= cyc;
      if (conv_track) run <= run + 1;
      if (conv_start) begin
         if (starts == mark) begin
            first_trk <= run;
            first_lat <= cyc - t0;
         end
         starts <= starts + 1;
         run <= 0;
      end
      if (conv_done) begin
         dones <= dones + 1;
         sum <= sum + 16'(conv_data);
         lat <= 4'($unsigned($random(seed)) % 4 + 2);
         sample <= 10'($random(seed));
      end
   end
   task automatic give_verdict();
      $display("tests %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
      end while (pready !== 1'b1 && k < 9);
      if (pready !== 1'b1) begin
         failures++;
         give_verdict();
      end
      rv = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic wait_for(input int target, input logic on_irq);
      int k;
      k = 0;
      while ((on_irq ? irq !== 1'b1 : dones != target) && k < 5000) begin
         @(posedge ref_clk);
         k++;
      end
      if (on_irq ? irq !== 1'b1 : dones != target) begin
         failures++;
         give_verdict();
      end
   endtask
   task automatic kick();
      if ($random(seed) & 1) begin
         ext_start <= 1'b1;
         @(posedge ref_clk);
         ext_start <= 1'b0;
      end else apb(1'b1, `ADCBS_CTRL_OFS, ctrl | 32'h100);
   endtask
   task automatic burst(input int sel, input logic en, input logic bm);
      int n, tk, pw, gt, lt, d0, trk, pu;
      logic xt;
      logic [15:0] s0, r;
      n = (sel == 0 || sel > 5) ? 1 : 2 << sel;
      tk = $unsigned($random(seed)) % 16;
      pw = $unsigned($random(seed)) % 16;
      xt = 1'($random(seed));
      gt = ($random(seed) & 1) ? 0 : 32'hffff;
      lt = ($random(seed) & 1) ? 0 : $unsigned($random(seed)) % 32768;
      trk = tk + 2 + xt * `ADCBS_XTRK_CYC;
      pu = (bm && !en) ? (pw + 1) * `ADCBS_PWR_STEP_CYC : 0;
      ctrl = {25'h0, sel[2:0], 1'b0, xt, bm, en};
      apb(1'b1, `ADCBS_PWR_OFS, pw);
      apb(1'b1, `ADCBS_TRACK_OFS, tk);
      apb(1'b1, `ADCBS_GT_OFS, gt);
      apb(1'b1, `ADCBS_LT_OFS, lt);
      apb(1'b1, `ADCBS_CTRL_OFS, ctrl);
      mark = starts;
      d0 = dones;
      s0 = sum;
      for (int i = 0; i < (bm ? 1 : n); i++) begin
         chk("early irq", 0, irq);
         kick();
         wait_for(d0 + (bm ? n : i + 1), 1'b0);
         repeat (4) @(posedge ref_clk);
      end
      wait_for(0, 1'b1);
      // let the idle power level settle past the done cycle
      repeat (2) @(posedge ref_clk);
      r = sum - s0;
      chk("conversions", n, starts - mark);
      chk("first track", trk, first_trk);
      chk("start latency", trk + 1 + pu, first_lat);
      chk("power after", en, conv_power);
      apb(1'b0, `ADCBS_RESULT_OFS, 32'h0);
      chk("result", r, rv);
      apb(1'b0, `ADCBS_STATUS_OFS, 32'h0);
      chk("status", {30'h0, r > gt || r < lt, 1'b1}, rv);
      $display("burst test sel %0d en %0d burst %0d done", sel, en, bm);
   endtask
   // main sequence
   initial begin
      {rst_n, psel, penable, pwrite, ext_start} = 5'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      foreach (rst_tab[i]) begin
         apb(1'b0, rst_tab[i][39:32], 32'h0);
         chk("reset value", rst_tab[i][31:0], rv);
      end
      chk("unmapped error", 1, serr);
      $display("reset test done");
      apb(1'b1, `ADCBS_MASK_OFS, 32'h1);
      for (int i = 0; i < 16; i++) burst(i % 8, i < 8, 1'b1);
      burst(1, 1'b1, 1'b0);
      burst(0, 1'b1, 1'b0);
      apb(1'b1, `ADCBS_MASK_OFS, 32'h0);
      ctrl = 32'h0;
      apb(1'b1, `ADCBS_CTRL_OFS, ctrl);
      repeat (2) @(posedge ref_clk);
      chk("idle power", 0, conv_power);
      mark = starts;
      kick();
      repeat (4) @(posedge ref_clk);
      chk("refused start", mark, starts);
      chk("masked irq", 0, irq);
      apb(1'b1, `ADCBS_MASK_OFS, 32'h4);
      repeat (2) @(posedge ref_clk);
      chk("irq raised", 1, irq);
      apb(1'b0, `ADCBS_STATUS_OFS, 32'h0);
      chk("refused flag", 4, rv);
      repeat (2) @(posedge ref_clk);
      chk("irq cleared", 0, irq);
      $display("refusal test done");
      give_verdict();
   end
endmodule
